// File: common/btc_pkg.sv
`default_nettype none
// Shared constants and types of the BCD time and calendar core.
package btc_pkg;

  // Core clock rate and alarm flag latency.
  localparam int unsigned CLK_MHZ           = 200;
  localparam int unsigned ALARM_DELAY_NS    = 31000;
  localparam int unsigned ALARM_DELAY_CYC   = (ALARM_DELAY_NS * CLK_MHZ + 999) / 1000;
  // Oscillator ticks that make up one second.
  localparam int unsigned OSC_TICKS_PER_SEC = 32768;

  // Register addresses on the plain register port.
  localparam logic [3:0] ADDR_SEC   = 4'h0;
  localparam logic [3:0] ADDR_MIN   = 4'h1;
  localparam logic [3:0] ADDR_HOUR  = 4'h2;
  localparam logic [3:0] ADDR_WDAY  = 4'h3;
  localparam logic [3:0] ADDR_MDAY  = 4'h4;
  localparam logic [3:0] ADDR_MONTH = 4'h5;
  localparam logic [3:0] ADDR_YEAR  = 4'h6;
  localparam logic [3:0] ADDR_CTRL  = 4'he;
  localparam logic [3:0] ADDR_FLAGS = 4'hf;

  // Implemented bits of the counter fields up to month, and of the control register.
  localparam logic [7:0] MASK_SEC   = 8'h7f;
  localparam logic [7:0] MASK_MIN   = 8'h7f;
  localparam logic [7:0] MASK_HOUR  = 8'h3f;
  localparam logic [7:0] MASK_WDAY  = 8'h07;
  localparam logic [7:0] MASK_MDAY  = 8'h3f;
  localparam logic [7:0] MASK_MONTH = 8'h1f;
  localparam logic [7:0] MASK_CTRL  = 8'he7;

  // Field positions in the month, hour, control and flag registers.
  localparam int CENTURY_BIT = 7;
  localparam int HOUR_PM_BIT = 5;
  localparam int CTRL_H24    = 5;
  localparam int CTRL_WEEKLY_ALARM_ENABLE   = 6;
  localparam int CTRL_DAILY_ALARM_ENABLE   = 7;
  localparam int FLG_DAILY   = 0;
  localparam int FLG_WEEKLY  = 1;
  localparam int FLG_PERIOD  = 2;
  localparam int FLG_PON     = 4;
  localparam int FLG_XST     = 5;

  // Alarm channel indices.
  localparam int ALM_WEEKLY = 0;
  localparam int ALM_DAILY  = 1;

  // Periodic output modes held in control bits 2..0.
  localparam logic [2:0] PER_OFF       = 3'h0;
  localparam logic [2:0] PER_FIXED_LOW = 3'h1;
  localparam logic [2:0] PER_PULSE_2HZ = 3'h2;
  localparam logic [2:0] PER_PULSE_1HZ = 3'h3;
  localparam logic [2:0] PER_LVL_SEC   = 3'h4;
  localparam logic [2:0] PER_LVL_MIN   = 3'h5;
  localparam logic [2:0] PER_LVL_HOUR  = 3'h6;
  localparam logic [2:0] PER_LVL_MONTH = 3'h7;

  // BCD limits of the counters.
  localparam logic [7:0] BCD_59    = 8'h59;
  localparam logic [7:0] BCD_23    = 8'h23;
  localparam logic [4:0] BCD_H11   = 5'h11;
  localparam logic [4:0] BCD_H12   = 5'h12;
  localparam logic [4:0] BCD_H01   = 5'h01;
  localparam logic [7:0] BCD_ONE   = 8'h01;
  localparam logic [7:0] BCD_FEB   = 8'h02;
  localparam logic [7:0] BCD_DEC   = 8'h12;
  localparam logic [7:0] BCD_99    = 8'h99;
  localparam logic [7:0] WDAY_LAST = 8'h06;
  localparam logic [7:0] RESET_DAY = 8'h01;

  // Register port request.
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } btc_bus_req_t;

  // Time and calendar counters, BCD.
  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] wday;
    logic [7:0] mday;
    logic [7:0] month;
    logic       century;
    logic [7:0] year;
  } btc_time_t;

  // Alarm latency sequencer states.
  typedef enum logic [1:0] {
    ALM_IDLE = 2'b01,
    ALM_WAIT = 2'b10
  } btc_alm_st_t;

endpackage
`default_nettype wire

// File: rtl/btc_rtc.sv
`timescale 1ns/1ps
`default_nettype none

module btc_rtc #(
  parameter int unsigned PRESC_COUNT     = btc_pkg::OSC_TICKS_PER_SEC, // Ticks per second.
  parameter int unsigned ALARM_DELAY_CYC = btc_pkg::ALARM_DELAY_CYC    // Match to flag latency.
) (
  input  wire logic                  clk_in,        // Core clock, 200 MHz.
  input  wire logic                  rst_in,        // Asynchronous reset, active high.
  input  wire btc_pkg::btc_bus_req_t bus_in,        // Register port request.
  input  wire logic                  osc_tick_in,   // One-cycle pulse per oscillator period.
  input  wire logic                  por_in,        // Power-on detect pulse.
  input  wire logic                  osc_halt_in,   // Oscillation halt sensed.
  input  wire logic [1:0]            alarm_match_in, // Alarm compare match levels.
  output logic [7:0]                 rd_data_out,   // Read data, one cycle after strobe.
  output logic                       irq_out_n      // Interrupt output, active low.
);

  localparam int PRESC_W = $clog2(PRESC_COUNT);
  localparam int ALM_W   = $clog2(ALARM_DELAY_CYC + 1);
  localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(PRESC_COUNT - 1);
  localparam logic [ALM_W-1:0]   ALM_LOAD   = ALM_W'(ALARM_DELAY_CYC);
  localparam logic [ALM_W-1:0]   ALM_ONE    = ALM_W'(1);

  // BCD increment of a two-digit value.
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // Hour advance; bit 6 of the result is the day carry.
  function automatic logic [6:0] hour_inc(input logic [7:0] h, input logic h24);
    logic       pm;
    logic [4:0] lo;
    logic [7:0] nxt;
    pm  = h[btc_pkg::HOUR_PM_BIT];
    lo  = h[4:0];
    nxt = bcd_inc(h);
    if (h24) begin
      if (h == btc_pkg::BCD_23) begin
        hour_inc = {1'b1, 6'h00};
      end else begin
        hour_inc = {1'b0, nxt[5:0]};
      end
    end else if (lo == btc_pkg::BCD_H11) begin
      // Eleven rolls into twelve and flips the half; PM11 gives the carry.
      hour_inc = {pm, ~pm, btc_pkg::BCD_H12};
    end else if (lo == btc_pkg::BCD_H12) begin
      hour_inc = {1'b0, pm, btc_pkg::BCD_H01};
    end else begin
      hour_inc = {1'b0, pm, nxt[4:0]};
    end
  endfunction

  // Leap year for a BCD year: every multiple of four, 00 included.
  function automatic logic is_leap(input logic [7:0] y);
    if (y[4]) begin
      is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end else begin
      is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    end
  endfunction

  // Last day of a BCD month.
  function automatic logic [7:0] last_day(input logic [7:0] m, input logic [7:0] y);
    case (m)
      btc_pkg::BCD_FEB: last_day = is_leap(y) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
      default: last_day = 8'h31;
    endcase
  endfunction

  // Register port decode.
  function automatic logic wr_hit(input btc_pkg::btc_bus_req_t b, input logic [3:0] a);
    wr_hit = b.wr && (b.addr == a);
  endfunction

  // Counter state.
  btc_pkg::btc_time_t tm_q;          // Time and calendar counters.
  btc_pkg::btc_time_t tm_d;          // Next counter values.
  logic [PRESC_W-1:0] presc_q;       // Sub-second prescaler.
  logic [PRESC_W-1:0] presc_d;       // Next prescaler value.
  logic               sec_tick;      // Seconds advance this cycle.
  logic               min_carry;     // Seconds wrapped.
  logic               hour_carry;    // Minutes wrapped.
  logic               day_carry;     // Hours wrapped.
  logic               month_carry;   // Day of month reverted to one.
  logic [6:0]         hour_next;     // Hour advance with carry.

  // Control and flag state.
  logic [7:0]         ctrl_q;        // Periodic mode, hour mode, alarm enables.
  logic [7:0]         ctrl_d;
  logic               pon_q;         // Power-on flag.
  logic               pon_d;
  logic               xst_q;         // Oscillation normal indicator, zero after a halt.
  logic               xst_d;
  logic               per_flag_q;    // Periodic level-mode flag.
  logic               per_flag_d;
  logic [1:0]         alm_flag_q;    // Alarm flags.
  logic [1:0]         alm_flag_d;
  logic [1:0]         match_q;       // Previous alarm match level.
  btc_pkg::btc_alm_st_t alm_st_q [2]; // Alarm latency sequencers.
  btc_pkg::btc_alm_st_t alm_st_d [2];
  logic [ALM_W-1:0]   alm_cnt_q [2]; // Alarm latency counters.
  logic [ALM_W-1:0]   alm_cnt_d [2];
  logic               per_low;       // Periodic source holds the output low.
  logic               per_event;     // Level-mode periodic event.
  logic [7:0]         flags_rd;      // Read view of the flag register.
  logic [7:0]         rd_data_d;     // Next read data.
  logic               irq_d;         // Next interrupt level, active low.

  // Prescaler and counter chain. A write lands on its own field and wins
  // over a carry in the same cycle; invalid written values are the host's
  // problem and may misbehave at the next carry.
  always_comb begin
    tm_d        = tm_q;
    presc_d     = presc_q;
    sec_tick    = 1'b0;
    min_carry   = 1'b0;
    hour_carry  = 1'b0;
    day_carry   = 1'b0;
    month_carry = 1'b0;
    hour_next   = hour_inc(tm_q.hour, ctrl_q[btc_pkg::CTRL_H24]);
    if (osc_tick_in) begin
      if (presc_q == PRESC_LAST) begin
        presc_d  = '0;
        sec_tick = 1'b1;
      end else begin
        presc_d = presc_q + 1'b1;
      end
    end
    if (sec_tick) begin
      if (tm_q.sec == btc_pkg::BCD_59) begin
        tm_d.sec  = 8'h00;
        min_carry = 1'b1;
      end else begin
        tm_d.sec = bcd_inc(tm_q.sec);
      end
    end
    if (min_carry) begin
      if (tm_q.min == btc_pkg::BCD_59) begin
        tm_d.min   = 8'h00;
        hour_carry = 1'b1;
      end else begin
        tm_d.min = bcd_inc(tm_q.min);
      end
    end
    if (hour_carry) begin
      tm_d.hour = {2'b00, hour_next[5:0]};
      day_carry = hour_next[6];
    end
    if (day_carry) begin
      // Weekday runs 0..6 and back to 0.
      if (tm_q.wday >= btc_pkg::WDAY_LAST) begin
        tm_d.wday = 8'h00;
      end else begin
        tm_d.wday = tm_q.wday + 8'h01;
      end
      if (tm_q.mday == last_day(tm_q.month, tm_q.year)) begin
        tm_d.mday   = btc_pkg::BCD_ONE;
        month_carry = 1'b1;
      end else begin
        tm_d.mday = bcd_inc(tm_q.mday);
      end
    end
    if (month_carry) begin
      if (tm_q.month == btc_pkg::BCD_DEC) begin
        tm_d.month = btc_pkg::BCD_ONE;
        if (tm_q.year == btc_pkg::BCD_99) begin
          tm_d.year    = 8'h00;
          tm_d.century = ~tm_q.century;
        end else begin
          tm_d.year = bcd_inc(tm_q.year);
        end
      end else begin
        tm_d.month = bcd_inc(tm_q.month);
      end
    end
    // Host writes; unused upper bits are masked off.
    if (wr_hit(bus_in, btc_pkg::ADDR_SEC)) begin
      tm_d.sec = bus_in.wdata & btc_pkg::MASK_SEC;
      presc_d  = '0;
    end
    if (wr_hit(bus_in, btc_pkg::ADDR_MIN)) begin
      tm_d.min = bus_in.wdata & btc_pkg::MASK_MIN;
    end
    if (wr_hit(bus_in, btc_pkg::ADDR_HOUR)) begin
      tm_d.hour = bus_in.wdata & btc_pkg::MASK_HOUR;
    end
    if (wr_hit(bus_in, btc_pkg::ADDR_WDAY)) begin
      tm_d.wday = bus_in.wdata & btc_pkg::MASK_WDAY;
    end
    if (wr_hit(bus_in, btc_pkg::ADDR_MDAY)) begin
      tm_d.mday = bus_in.wdata & btc_pkg::MASK_MDAY;
    end
    if (wr_hit(bus_in, btc_pkg::ADDR_MONTH)) begin
      tm_d.month   = bus_in.wdata & btc_pkg::MASK_MONTH;
      tm_d.century = bus_in.wdata[btc_pkg::CENTURY_BIT];
    end
    if (wr_hit(bus_in, btc_pkg::ADDR_YEAR)) begin
      tm_d.year = bus_in.wdata;
    end
  end

  // Counter registers. Counters start at midnight on day one of year 00.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tm_q         <= '0;
      tm_q.hour    <= btc_pkg::BCD_H12; // Midnight in 12-hour mode, the hour mode after reset.
      tm_q.mday    <= btc_pkg::RESET_DAY;
      tm_q.month   <= btc_pkg::RESET_DAY;
      presc_q      <= '0;
    end else begin
      tm_q    <= tm_d;
      presc_q <= presc_d;
    end
  end

  // Periodic source. Pulse modes take their 50 percent low phase from the
  // prescaler, so the falling edge lines up with the seconds increment and
  // a seconds write drives the output low at once.
  always_comb begin
    per_low   = 1'b0;
    per_event = 1'b0;
    case (ctrl_q[2:0])
      btc_pkg::PER_OFF:       per_low = 1'b0;
      btc_pkg::PER_FIXED_LOW: per_low = 1'b1;
      btc_pkg::PER_PULSE_2HZ: per_low = ~presc_q[PRESC_W-2];
      btc_pkg::PER_PULSE_1HZ: per_low = ~presc_q[PRESC_W-1];
      btc_pkg::PER_LVL_SEC: begin
        per_low   = per_flag_q;
        per_event = sec_tick;
      end
      btc_pkg::PER_LVL_MIN: begin
        per_low   = per_flag_q;
        per_event = min_carry;
      end
      btc_pkg::PER_LVL_HOUR: begin
        per_low   = per_flag_q;
        per_event = hour_carry;
      end
      btc_pkg::PER_LVL_MONTH: begin
        per_low   = per_flag_q;
        per_event = month_carry;
      end
      default: per_low = 1'b0;
    endcase
  end

  // Control, flags and alarm latency. Hardware sets win over software
  // clears in the same cycle, so no event is lost.
  always_comb begin
    ctrl_d     = ctrl_q;
    pon_d      = pon_q;
    xst_d      = xst_q;
    per_flag_d = per_flag_q;
    alm_flag_d = alm_flag_q;
    alm_st_d   = alm_st_q;
    alm_cnt_d  = alm_cnt_q;
    if (wr_hit(bus_in, btc_pkg::ADDR_CTRL)) begin
      ctrl_d = bus_in.wdata & btc_pkg::MASK_CTRL;
    end
    if (wr_hit(bus_in, btc_pkg::ADDR_FLAGS)) begin
      xst_d = bus_in.wdata[btc_pkg::FLG_XST];
      // Power-on, alarm and periodic flags accept only a zero.
      if (!bus_in.wdata[btc_pkg::FLG_PON]) begin
        pon_d = 1'b0;
      end
      if (!bus_in.wdata[btc_pkg::FLG_WEEKLY]) begin
        alm_flag_d[btc_pkg::ALM_WEEKLY] = 1'b0;
      end
      if (!bus_in.wdata[btc_pkg::FLG_DAILY]) begin
        alm_flag_d[btc_pkg::ALM_DAILY] = 1'b0;
      end
      if (!bus_in.wdata[btc_pkg::FLG_PERIOD] && ctrl_q[2]) begin
        per_flag_d = 1'b0;
      end
    end
    // The stored flag is only meaningful in level mode.
    if (!ctrl_q[2]) begin
      per_flag_d = 1'b0;
    end else if (per_event) begin
      per_flag_d = 1'b1;
    end
    // Each alarm waits the fixed latency after a new match, then sets.
    for (int i = 0; i < 2; i++) begin
      case (alm_st_q[i])
        btc_pkg::ALM_IDLE: begin
          if (alarm_match_in[i] && !match_q[i]) begin
            alm_st_d[i]  = btc_pkg::ALM_WAIT;
            alm_cnt_d[i] = ALM_LOAD;
          end
        end
        btc_pkg::ALM_WAIT: begin
          if (alm_cnt_q[i] == ALM_ONE) begin
            alm_st_d[i]   = btc_pkg::ALM_IDLE;
            alm_flag_d[i] = 1'b1;
          end else begin
            alm_cnt_d[i] = alm_cnt_q[i] - ALM_ONE;
          end
        end
        default: alm_st_d[i] = btc_pkg::ALM_IDLE;
      endcase
    end
    // A disabled alarm keeps its flag and sequencer cleared.
    if (!ctrl_q[btc_pkg::CTRL_WEEKLY_ALARM_ENABLE]) begin
      alm_flag_d[btc_pkg::ALM_WEEKLY] = 1'b0;
      alm_st_d[btc_pkg::ALM_WEEKLY]   = btc_pkg::ALM_IDLE;
    end
    if (!ctrl_q[btc_pkg::CTRL_DAILY_ALARM_ENABLE]) begin
      alm_flag_d[btc_pkg::ALM_DAILY] = 1'b0;
      alm_st_d[btc_pkg::ALM_DAILY]   = btc_pkg::ALM_IDLE;
    end
    // Halt detection beats a host write of one.
    if (osc_halt_in) begin
      xst_d = 1'b0;
    end
    // Power-on clears control, periodic and alarm flags and sequencers; counters and the halt flag are kept.
    if (por_in) begin
      pon_d      = 1'b1;
      ctrl_d     = '0;
      per_flag_d = 1'b0;
      alm_flag_d = '0;
      alm_st_d   = '{btc_pkg::ALM_IDLE, btc_pkg::ALM_IDLE};
    end
  end

  // Read view and output level computed from the same registered state terms,
  // so the flags and the pin change in the same clock edge.
  always_comb begin
    flags_rd = '0;
    flags_rd[btc_pkg::FLG_XST]    = xst_q;
    flags_rd[btc_pkg::FLG_PON]    = pon_q;
    flags_rd[btc_pkg::FLG_PERIOD] = per_low;
    flags_rd[btc_pkg::FLG_WEEKLY] = alm_flag_q[btc_pkg::ALM_WEEKLY];
    flags_rd[btc_pkg::FLG_DAILY]  = alm_flag_q[btc_pkg::ALM_DAILY];
    irq_d = ~(per_low | (|alm_flag_q));
    rd_data_d = 8'h00;
    if (bus_in.rd) begin
      case (bus_in.addr)
        btc_pkg::ADDR_SEC:   rd_data_d = tm_q.sec;
        btc_pkg::ADDR_MIN:   rd_data_d = tm_q.min;
        btc_pkg::ADDR_HOUR:  rd_data_d = tm_q.hour;
        btc_pkg::ADDR_WDAY:  rd_data_d = tm_q.wday;
        btc_pkg::ADDR_MDAY:  rd_data_d = tm_q.mday;
        btc_pkg::ADDR_MONTH: rd_data_d = {tm_q.century, 2'b00, tm_q.month[4:0]};
        btc_pkg::ADDR_YEAR:  rd_data_d = tm_q.year;
        btc_pkg::ADDR_CTRL:  rd_data_d = ctrl_q;
        btc_pkg::ADDR_FLAGS: rd_data_d = flags_rd;
        default:             rd_data_d = 8'h00;
      endcase
    end
  end

  // Control, flag and output registers. The power-on flag is up after reset.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_q      <= '0;
      pon_q       <= 1'b1;
      xst_q       <= 1'b0;
      per_flag_q  <= 1'b0;
      alm_flag_q  <= '0;
      match_q     <= '0;
      alm_st_q    <= '{btc_pkg::ALM_IDLE, btc_pkg::ALM_IDLE};
      alm_cnt_q   <= '{'0, '0};
      rd_data_out <= 8'h00;
      irq_out_n   <= 1'b1;
    end else begin
      ctrl_q      <= ctrl_d;
      pon_q       <= pon_d;
      xst_q       <= xst_d;
      per_flag_q  <= per_flag_d;
      alm_flag_q  <= alm_flag_d;
      match_q     <= alarm_match_in;
      alm_st_q    <= alm_st_d;
      alm_cnt_q   <= alm_cnt_d;
      rd_data_out <= rd_data_d;
      irq_out_n   <= irq_d;
    end
  end

endmodule // btc_rtc
`default_nettype wire

// File: sim/btc_rtc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// Port-side checker; the control byte is shadowed from bus writes.
module btc_rtc_monitor #(
  parameter int unsigned PRESC_COUNT     = 8, // Ticks per second.
  parameter int unsigned ALARM_DELAY_CYC = 5  // Match to flag latency.
) (
  input wire logic                  clk_in,
  input wire logic                  rst_in,
  input wire btc_pkg::btc_bus_req_t bus_in,
  input wire logic                  osc_tick_in,
  input wire logic                  por_in,
  input wire logic                  osc_halt_in,
  input wire logic [1:0]            alarm_match_in,
  input wire logic [7:0]            rd_data_out,
  input wire logic                  irq_out_n
);
  logic [7:0] ctrl_q; // Shadow of the control register.
  logic [7:0] ctrl_d; // Next shadow value.
  // Power-on wins over a write, as it does in the core.
  always_comb begin
    ctrl_d = ctrl_q;
    if (bus_in.wr && bus_in.addr == btc_pkg::ADDR_CTRL) begin
      ctrl_d = bus_in.wdata & btc_pkg::MASK_CTRL;
    end
    if (por_in) begin
      ctrl_d = 8'h00;
    end
  end
  // The shadow only registers its next value.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_q <= 8'h00;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  AST_RD_IDLE: assert property (!$past(bus_in.rd) |-> rd_data_out == 8'h00)
    else $error("read data not zero outside a read");
  AST_SEC_BCD: assert property ($past(bus_in.rd) && $past(bus_in.addr) == btc_pkg::ADDR_SEC
    |-> rd_data_out <= btc_pkg::BCD_59 && rd_data_out[3:0] <= 4'h9)
    else $error("seconds out of range");
  AST_MIN_BCD: assert property ($past(bus_in.rd) && $past(bus_in.addr) == btc_pkg::ADDR_MIN
    |-> rd_data_out <= btc_pkg::BCD_59 && rd_data_out[3:0] <= 4'h9)
    else $error("minutes out of range");
  AST_HOUR_TOP: assert property ($past(bus_in.rd) && $past(bus_in.addr) == btc_pkg::ADDR_HOUR
    |-> rd_data_out[7:6] == 2'b00 && rd_data_out[3:0] <= 4'h9)
    else $error("hour digits malformed");
  AST_WDAY_RANGE: assert property ($past(bus_in.rd) && $past(bus_in.addr) == btc_pkg::ADDR_WDAY
    |-> rd_data_out <= btc_pkg::WDAY_LAST)
    else $error("weekday beyond six");
  AST_MDAY_RANGE: assert property ($past(bus_in.rd) && $past(bus_in.addr) == btc_pkg::ADDR_MDAY
    |-> rd_data_out != 8'h00 && rd_data_out <= 8'h31)
    else $error("day of month out of range");
  AST_MONTH_RANGE: assert property ($past(bus_in.rd) && $past(bus_in.addr) == btc_pkg::ADDR_MONTH
    |-> rd_data_out[6:5] == 2'b00 && rd_data_out[4:0] != 5'h00 && rd_data_out[4:0] <= 5'h12)
    else $error("month out of range");
  AST_POR_QUIET: assert property (por_in |-> ##2 irq_out_n)
    else $error("interrupt active after power-on");
  AST_ALARM_DELAY: assert property ($rose(alarm_match_in[btc_pkg::ALM_WEEKLY])
    && ctrl_q[btc_pkg::CTRL_WEEKLY_ALARM_ENABLE] && ctrl_q[2:0] == btc_pkg::PER_OFF && irq_out_n
    |-> ##ALARM_DELAY_CYC irq_out_n ##1 irq_out_n ##1 !irq_out_n)
    else $error("alarm latency wrong");
  AST_FLAG_CLEAR: assert property (bus_in.wr && bus_in.addr == btc_pkg::ADDR_FLAGS
    && bus_in.wdata[2:0] == 3'h0 && ctrl_q[2:0] == btc_pkg::PER_OFF |-> ##2 irq_out_n)
    else $error("interrupt not released by clear");
  AST_FIXED_LOW: assert property (ctrl_q[2:0] == btc_pkg::PER_FIXED_LOW [*2] |-> !irq_out_n)
    else $error("fixed low mode not driving low");
  COV_IRQ: cover property ($fell(irq_out_n));
  COV_POR: cover property (por_in);
  COV_YEAR: cover property ($past(bus_in.rd) && $past(bus_in.addr) == btc_pkg::ADDR_YEAR);
endmodule // btc_rtc_monitor
bind btc_rtc btc_rtc_monitor #(.PRESC_COUNT(PRESC_COUNT), .ALARM_DELAY_CYC(ALARM_DELAY_CYC))
  u_mon (.clk_in(clk_in), .rst_in(rst_in), .bus_in(bus_in), .osc_tick_in(osc_tick_in),
  .por_in(por_in), .osc_halt_in(osc_halt_in), .alarm_match_in(alarm_match_in),
  .rd_data_out(rd_data_out), .irq_out_n(irq_out_n));
`default_nettype wire

// File: sim/btc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host controller on the register port; one strobe per call.
module btc_host_model (
  input  wire logic                  clk_in,     // Core clock.
  input  wire logic [7:0]            rd_data_in, // Read data from the core.
  output var btc_pkg::btc_bus_req_t  bus_out     // Register port request.
);
  initial bus_out = '0;
  // Callers may set unused upper bits; once masked, times, dates and weekdays are real.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    bus_out <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    // Idle lines are inverted so a stale value is never mistaken for data.
    bus_out <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask
  // Data are taken mid-cycle after the strobe edge, clear of the update.
  task automatic rd(input logic [3:0] a, output logic [7:0] q);
    @(posedge clk_in);
    bus_out <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    bus_out <= '{addr: ~a, wdata: 8'hff, wr: 1'b0, rd: 1'b0};
    @(negedge clk_in);
    q = rd_data_in;
  endtask
endmodule // btc_host_model
`default_nettype wire

// File: sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench with a short second and a short alarm latency.
module tb;
  localparam int unsigned PRESC = 8; // Shortened second.
  localparam int unsigned ALMD  = 5; // Shortened alarm latency.
  localparam logic [7:0] RST [7] = '{8'h00, 8'h00, 8'h12, 8'h00, 8'h01, 8'h01, 8'h00};
  localparam logic [7:0] WV [6] = '{8'hd9, 8'h85, 8'hc9, 8'hfd, 8'hd5, 8'h69};
  localparam logic [7:0] MK [6] = '{btc_pkg::MASK_SEC, btc_pkg::MASK_MIN, btc_pkg::MASK_HOUR,
    btc_pkg::MASK_WDAY, btc_pkg::MASK_MDAY, btc_pkg::MASK_MONTH};
  localparam logic [3:0] WA [6] = '{btc_pkg::ADDR_CTRL, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6};
  // Set: ctrl hour wday mday month year; then expected hour wday mday month year.
  localparam logic [87:0] CS [5] = '{88'h20_23_06_28_02_99_00_00_01_03_99,
    88'h20_23_02_28_02_04_00_03_29_02_04, 88'h07_31_00_31_12_99_12_01_01_81_00,
    88'h20_23_03_30_04_21_00_04_01_05_21, 88'h00_11_05_15_07_00_32_05_15_07_00};
  logic                  clk_in = 1'b0;
  logic                  rst_in = 1'b1;
  logic                  osc_tick_in = 1'b0;
  logic                  tick_en = 1'b0;
  logic                  por_in = 1'b0;
  logic [1:0]            alarm_match_in = 2'b00;
  btc_pkg::btc_bus_req_t bus;
  logic [7:0]            rd_data_out;
  logic                  irq_out_n;
  logic [7:0]            q;
  int                    n_mismatch = 0;
  int                    n_tests = 0;
  int                    seed = 32'h8eff;
  int                    n;
  always #2.5 clk_in = ~clk_in;
  // The oscillator tick runs only while a scenario lets time pass.
  always @(posedge clk_in) osc_tick_in <= tick_en;
  btc_rtc #(.PRESC_COUNT(PRESC), .ALARM_DELAY_CYC(ALMD)) uut (.clk_in(clk_in), .rst_in(rst_in),
    .bus_in(bus), .osc_tick_in(osc_tick_in), .por_in(por_in), .osc_halt_in(1'b0),
    .alarm_match_in(alarm_match_in), .rd_data_out(rd_data_out), .irq_out_n(irq_out_n));
  btc_host_model host (.clk_in(clk_in), .rd_data_in(rd_data_out), .bus_out(bus));
  function automatic logic [7:0] bcd(input int v);
    return 8'((v / 10) * 16 + v % 10);
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
    host.rd(a, q);
    chk(q, exp);
  endtask
  task automatic stop_test();
    $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // A hang anywhere counts as a mismatch.
  initial begin
    repeat (20000) @(posedge clk_in);
    n_mismatch++;
    stop_test();
  end
  initial begin
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 7; i++) rdchk(i[3:0], RST[i]);
    // Unused upper bits are written high and must read as zero.
    for (int i = 0; i < 6; i++) begin
      host.wr(i[3:0], WV[i]);
      rdchk(i[3:0], WV[i] & MK[i]);
    end
    host.wr(4'h8, 8'h5a);
    rdchk(4'h8, 8'h00);
    // A seconds write restarts the second, so the advance comes a full second later.
    for (int k = 0; k < 5; k++) begin
      n = $unsigned($random(seed)) % 59;
      host.wr(btc_pkg::ADDR_SEC, bcd(n));
      tick_en <= 1'b1;
      repeat (PRESC - 2) @(posedge clk_in);
      rdchk(btc_pkg::ADDR_SEC, bcd(n));
      repeat (4) @(posedge clk_in);
      tick_en <= 1'b0;
      rdchk(btc_pkg::ADDR_SEC, bcd(n + 1));
    end
    // One second before each boundary, then the whole carry chain is read.
    for (int c = 0; c < 5; c++) begin
      for (int j = 0; j < 6; j++) host.wr(WA[j], CS[c][87 - 8 * j -: 8]);
      host.wr(btc_pkg::ADDR_MIN, 8'h59);
      host.wr(btc_pkg::ADDR_SEC, 8'h59);
      tick_en <= 1'b1;
      repeat (PRESC + 3) @(posedge clk_in);
      tick_en <= 1'b0;
      rdchk(btc_pkg::ADDR_SEC, 8'h00);
      rdchk(btc_pkg::ADDR_MIN, 8'h00);
      for (int j = 0; j < 5; j++) rdchk(WA[j + 1], CS[c][39 - 8 * j -: 8]);
      // Only the third case runs the once-per-month level mode.
      chk({7'h00, irq_out_n}, {7'h00, c != 2});
    end
    // Each alarm channel: latency, write one ignored, clear, repeat, disable.
    for (int i = 0; i < 2; i++) begin
      host.wr(btc_pkg::ADDR_CTRL, (i == 1) ? 8'h80 : 8'h40);
      alarm_match_in[i] <= 1'b1;
      repeat (2) @(posedge clk_in);
      host.rd(btc_pkg::ADDR_FLAGS, q);
      chk({7'h00, q[1 - i]}, 8'h00);
      repeat (ALMD) @(posedge clk_in);
      host.rd(btc_pkg::ADDR_FLAGS, q);
      chk({7'h00, q[1 - i]}, 8'h01);
      chk({7'h00, irq_out_n}, 8'h00);
      host.wr(btc_pkg::ADDR_FLAGS, 8'hff);
      host.rd(btc_pkg::ADDR_FLAGS, q);
      chk({7'h00, q[1 - i]}, 8'h01);
      host.wr(btc_pkg::ADDR_FLAGS, 8'h00);
      host.rd(btc_pkg::ADDR_FLAGS, q);
      chk({6'h00, q[1 - i], irq_out_n}, 8'h01);
      alarm_match_in[i] <= 1'b0;
      @(posedge clk_in);
      alarm_match_in[i] <= 1'b1;
      repeat (ALMD + 3) @(negedge clk_in);
      chk({7'h00, irq_out_n}, 8'h00);
      host.wr(btc_pkg::ADDR_CTRL, 8'h00);
      @(posedge clk_in);
      host.rd(btc_pkg::ADDR_FLAGS, q);
      chk({6'h00, q[1 - i], irq_out_n}, 8'h01);
      alarm_match_in[i] <= 1'b0;
    end
    // Level mode once per second: flag follows the output, a zero write releases it.
    host.wr(btc_pkg::ADDR_CTRL, 8'h24);
    tick_en <= 1'b1;
    n = 0;
    while (irq_out_n !== 1'b0 && n < 40) begin
      @(negedge clk_in);
      n++;
    end
    tick_en <= 1'b0;
    if (n == 40) n_mismatch++;
    host.rd(btc_pkg::ADDR_FLAGS, q);
    chk({7'h00, q[2]}, 8'h01);
    host.wr(btc_pkg::ADDR_FLAGS, 8'h00);
    host.rd(btc_pkg::ADDR_FLAGS, q);
    chk({6'h00, q[2], irq_out_n}, 8'h01);
    host.wr(btc_pkg::ADDR_CTRL, 8'h01);
    repeat (2) @(posedge clk_in);
    host.rd(btc_pkg::ADDR_FLAGS, q);
    chk({6'h00, q[2], irq_out_n}, 8'h02);
    // Power-on clears control and stops the output but sets the power-on flag.
    @(posedge clk_in);
    por_in <= 1'b1;
    @(posedge clk_in);
    por_in <= 1'b0;
    rdchk(btc_pkg::ADDR_CTRL, 8'h00);
    host.rd(btc_pkg::ADDR_FLAGS, q);
    chk({6'h00, q[4], irq_out_n}, 8'h03);
    stop_test();
  end
endmodule // tb
`default_nettype wire
